/* File: common/mcc_pkg.sv */
// Constants, register layout and timing for the main clock controller.
// Assumes a single oscillator-rate clock and an APB slave for registers.
// Contract
// - Prescaler, clock-out and timer run independently.
// - CPU clock prescale set by fields.
// - Clock-out select drives oscillator clock out; the pin toggles every cycle, at half the oscillator rate.
// - Clock-out stops during active halt.
// - Timer offers four periods from oscillator.
// - Interrupt enable makes halt become active halt.
// - Beeper outputs one of three tones.
// - Wait mode runs on; overflow wakes.
// - Active halt: counter runs, CSR and beeper writes frozen.
// - Full halt freezes counter, CSR and beeper writes.
// - Interrupt needs enable and unmasked CPU; the irq output needs only IMASK set.
// - Overflow flag; wakes wait and active halt, not full halt.
// - Slow mode divides by 2,4,8,16.
// - Periods 16000, 32000, 80000, 200000 cycles.
// - Period change waits for current period end.
// - Flag set on period, cleared by read.
package mcc_pkg;
  localparam logic [11:0] MCC_ADDR_CSR   = 12'h000;
  localparam logic [11:0] MCC_ADDR_BEEP  = 12'h004;
  localparam logic [11:0] MCC_ADDR_ISTAT = 12'h008;
  localparam logic [11:0] MCC_ADDR_IMASK = 12'h00C;
  localparam int MCC_ADDR_W = 12;
  localparam int MCC_BIT_MCO  = 7;
  localparam int MCC_BIT_CPH  = 6;
  localparam int MCC_BIT_CPL  = 5;
  localparam int MCC_BIT_SMS  = 4;
  localparam int MCC_BIT_TBH  = 3;
  localparam int MCC_BIT_TBL  = 2;
  localparam int MCC_BIT_OIE  = 1;
  localparam int MCC_BIT_OIF  = 0;
  localparam logic [7:0] MCC_CSR_RST  = 8'h00;
  localparam logic [1:0] MCC_BEEP_RST = 2'h0;
  localparam logic [0:0] MCC_MASK_RST = 1'h0;
  localparam int MCC_TB_W = 18;
  localparam logic [17:0] MCC_TB_P0 = 18'd16000;
  localparam logic [17:0] MCC_TB_P1 = 18'd32000;
  localparam logic [17:0] MCC_TB_P2 = 18'd80000;
  localparam logic [17:0] MCC_TB_P3 = 18'd200000;
  localparam int MCC_BEEP_W = 12;
  localparam logic [11:0] MCC_BEEP_H1 = 12'd250;
  localparam logic [11:0] MCC_BEEP_H2 = 12'd500;
  localparam logic [11:0] MCC_BEEP_H3 = 12'd1000;
  localparam logic [3:0] MCC_ONE4 = 4'h1;
  localparam logic [17:0] MCC_ONE18 = 18'h1;
  localparam logic [11:0] MCC_ONE12 = 12'h1;
  typedef enum logic [2:0] {
    MCC_RUN   = 3'b001,
    MCC_AHALT = 3'b010,
    MCC_FHALT = 3'b100
  } mcc_pmode_t;
endpackage

/* File: rtl/mcc_top.sv */
// Main clock controller: CPU prescaler, clock-out, time base timer, beeper.
// Assumes APB master on the oscillator clock; CPU gives halt/wake/mask levels.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mcc_top #(
  parameter int TB_P0 = 16000,
  parameter int TB_P1 = 32000,
  parameter int TB_P2 = 80000,
  parameter int TB_P3 = 200000
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           nrst,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [mcc_pkg::MCC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // CPU side
  input  wire logic                           halt_req,
  input  wire logic                           halt_wake,
  input  wire logic                           cpu_irq_masked,
  output logic                                cpu_clk_en,
  output logic                                timebase_irq,
  output logic                                wake_from_wait,
  output logic                                active_halt,
  // Pins
  output logic                                clk_out_en,
  output logic                                clk_out_pin,
  output logic                                tone_en,
  output logic                                tone_out_pin,
  // Interrupt
  output logic                                irq
);
  import mcc_pkg::*;

  logic       rs1_q, rs2_q;
  logic [7:0] csr_q, csr_d;
  logic [1:0] beep_q;
  logic       istat_q, imask_q;
  mcc_pmode_t pm_q, pm_d;
  logic [MCC_TB_W-1:0] tb_cnt_q, tb_lim_q;
  logic [3:0]  pre_q;
  logic [MCC_BEEP_W-1:0] bp_cnt_q;
  logic        bp_q, co_q, tone_en_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, irq_q, tbirq_q, wake_q, cpuen_q;

  function automatic logic [MCC_TB_W-1:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'h0: tb_period = MCC_TB_W'(TB_P0);
      2'h1: tb_period = MCC_TB_W'(TB_P1);
      2'h2: tb_period = MCC_TB_W'(TB_P2);
      default: tb_period = MCC_TB_W'(TB_P3);
    endcase
  endfunction

  // Reset synchroniser
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire rst_n = rs2_q;

  // APB decode
  wire acc     = psel && penable && !pready_q;
  // Writes land at the edge where the master samples pready high
  wire wr      = psel && penable && pready_q && pwrite;
  wire rd      = acc && !pwrite;
  wire hit_csr = paddr == MCC_ADDR_CSR;
  wire hit_bp  = paddr == MCC_ADDR_BEEP;
  wire hit_is  = paddr == MCC_ADDR_ISTAT;
  wire hit_im  = paddr == MCC_ADDR_IMASK;
  wire mapped  = hit_csr || hit_bp || hit_is || hit_im;
  wire frozen  = pm_q != MCC_RUN;
  wire tb_run  = pm_q != MCC_FHALT;
  wire tb_end  = tb_run && (tb_cnt_q == tb_lim_q - MCC_ONE18);
  wire timebase_irq_enable     = csr_q[MCC_BIT_OIE];
  wire slow_mode_select     = csr_q[MCC_BIT_SMS];
  wire [1:0] cp = csr_q[MCC_BIT_CPH:MCC_BIT_CPL];
  wire [1:0] tb = csr_q[MCC_BIT_TBH:MCC_BIT_TBL];
  wire [2:0] cp_sh = {1'b0, cp} + 3'h1; // Three bits so divide by 16 does not wrap
  wire [3:0] pre_mask = (MCC_ONE4 << cp_sh) - MCC_ONE4;
  wire [MCC_BEEP_W-1:0] bp_half = (beep_q == 2'h1) ? MCC_BEEP_H1 :
                                  (beep_q == 2'h2) ? MCC_BEEP_H2 : MCC_BEEP_H3;
  wire [31:0] rd_val = hit_csr ? {24'h0, csr_q} :
                       hit_bp  ? {30'h0, beep_q} :
                       hit_is  ? {31'h0, istat_q} :
                       hit_im  ? {31'h0, imask_q} : 32'h0;
  wire csr_wr = wr && hit_csr && !frozen;

  // Control/status next value; hardware set of the flag wins over read clear
  always_comb begin
    csr_d = csr_q;
    if (csr_wr) begin
      csr_d[7:1] = pwdata[7:1];
    end
    if (rd && hit_csr) begin
      csr_d[MCC_BIT_OIF] = 1'b0;
    end
    if (tb_end) begin
      csr_d[MCC_BIT_OIF] = 1'b1;
    end
  end

  // Power mode: halt becomes active halt when interrupt enabled
  always_comb begin
    pm_d = pm_q;
    case (pm_q)
      MCC_RUN: begin
        if (halt_req) begin
          pm_d = timebase_irq_enable ? MCC_AHALT : MCC_FHALT;
        end
      end
      MCC_AHALT: begin
        if (halt_wake || (tb_end && timebase_irq_enable)) begin
          pm_d = MCC_RUN;
        end
      end
      MCC_FHALT: begin
        if (halt_wake) begin
          pm_d = MCC_RUN;
        end
      end
      default: pm_d = MCC_RUN;
    endcase
  end

  // Registers and mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csr_q   <= MCC_CSR_RST;
      beep_q  <= MCC_BEEP_RST;
      imask_q <= MCC_MASK_RST;
      istat_q <= 1'b0;
      pm_q    <= MCC_RUN;
    end else begin
      csr_q   <= csr_d;
      pm_q    <= pm_d;
      if (wr && hit_bp && !frozen) beep_q <= pwdata[1:0];
      if (wr && hit_im) imask_q <= pwdata[0];
      if (tb_end) istat_q <= 1'b1;
      else if (rd && hit_is) istat_q <= 1'b0;
    end
  end

  // Time base counter; new period loaded only at period end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt_q <= '0;
      tb_lim_q <= MCC_TB_W'(TB_P0);
    end else if (tb_end) begin
      tb_cnt_q <= '0;
      tb_lim_q <= tb_period(tb);
    end else if (tb_run) begin
      tb_cnt_q <= tb_cnt_q + MCC_ONE18;
    end
  end

  // CPU prescaler, clock-out and beeper
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q    <= '0;
      cpuen_q  <= 1'b0;
      co_q     <= 1'b0;
      bp_cnt_q <= '0;
      bp_q     <= 1'b0;
      tone_en_q <= 1'b0;
    end else begin
      tone_en_q <= beep_q != 2'h0;
      pre_q   <= (pre_q & pre_mask) == pre_mask ? 4'h0 : pre_q + MCC_ONE4;
      cpuen_q <= !slow_mode_select || ((pre_q & pre_mask) == pre_mask);
      co_q    <= csr_q[MCC_BIT_MCO] && (pm_q == MCC_RUN) && !co_q;
      if (beep_q == 2'h0 || frozen) begin
        bp_cnt_q <= '0;
        bp_q     <= 1'b0;
      end else if (bp_cnt_q >= bp_half - MCC_ONE12) begin
        bp_cnt_q <= '0;
        bp_q     <= !bp_q;
      end else begin
        bp_cnt_q <= bp_cnt_q + MCC_ONE12;
      end
    end
  end

  // Bus answer and interrupt outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
      tbirq_q   <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= rd ? rd_val : 32'h0;
      tbirq_q   <= csr_d[MCC_BIT_OIF] && timebase_irq_enable && !cpu_irq_masked;
      wake_q    <= tb_end && timebase_irq_enable;
      irq_q     <= (istat_q || tb_end) && imask_q;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign cpu_clk_en     = cpuen_q;
  assign timebase_irq   = tbirq_q;
  assign wake_from_wait = wake_q;
  assign active_halt    = pm_q[1];
  assign clk_out_en     = csr_q[MCC_BIT_MCO];
  assign clk_out_pin    = co_q;
  assign tone_en        = tone_en_q;
  assign tone_out_pin   = bp_q;
  assign irq            = irq_q;
endmodule
`default_nettype wire

/* File: testbench/mcc_cpu_model.sv */
// CPU core and interrupt controller model facing the clock controller.
// Assumes the bench commands halt, wake and the global interrupt mask.
`timescale 1ns/10ps
`default_nettype none
module mcc_cpu_model (
  input  wire logic clock, go_halt, go_wake, go_mask,
  output logic      halt_req, halt_wake, cpu_irq_masked
);
  // Halt and wake are one-cycle requests, the mask is a held level
  always_ff @(posedge clock) begin
    halt_req       <= go_halt;
    halt_wake      <= go_wake;
    cpu_irq_masked <= go_mask;
  end
endmodule
`default_nettype wire

/* File: testbench/mcc_top_properties.sv */
// Port timing checker for the main clock controller.
// Assumes it is bound into mcc_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mcc_chk (
  input wire logic clock, nrst, psel, penable, pready, pslverr, halt_req, cpu_irq_masked,
  input wire logic timebase_irq, wake_from_wait, active_halt, clk_out_en, clk_out_pin,
  input wire logic tone_en, tone_out_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Bus answer timing
  property p_ans; psel && $rose(penable) |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late pready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  // Interrupt and wake
  property p_msk; cpu_irq_masked |=> !timebase_irq; endproperty
  a_msk: assert property (p_msk) else $error("irq while masked");
  property p_wk; wake_from_wait |=> !wake_from_wait; endproperty
  a_wk: assert property (p_wk) else $error("long wake");
  property p_ovf; wake_from_wait && !cpu_irq_masked |-> ##[0:2] timebase_irq; endproperty
  a_ovf: assert property (p_ovf) else $error("no irq on overflow");
  property p_ah; $rose(active_halt) |-> $past(halt_req); endproperty
  a_ah: assert property (p_ah) else $error("halt without request");
  // Pins
  property p_ahc; active_halt [*2] |-> !clk_out_pin; endproperty
  a_ahc: assert property (p_ahc) else $error("clock out in halt");
  property p_off; !clk_out_en [*2] |-> !clk_out_pin; endproperty
  a_off: assert property (p_off) else $error("clock out unselected");
  property p_tone; !tone_en [*2] |-> !tone_out_pin; endproperty
  a_tone: assert property (p_tone) else $error("tone unselected");
  c_ah: cover property (active_halt);
  c_err: cover property (pslverr);
  c_wk: cover property (wake_from_wait);
endmodule
bind mcc_top mcc_chk i_chk (.*);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the main clock controller over APB.
// Assumes shortened timer periods and the CPU model beside the design.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, gh = 0, gm = 0, gw = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, halt_req, halt_wake, cpu_irq_masked, cpu_clk_en, timebase_irq;
  logic wake_from_wait, active_halt, clk_out_en, clk_out_pin, tone_en, tone_out_pin, irq;
  int num_errors = 0, samples_checked = 0, seed = 2, csr, n, i, k;
  int per[4] = '{16, 32, 80, 200};
  always #2 clock = ~clock;
  mcc_top #(.TB_P0(16), .TB_P1(32), .TB_P2(80), .TB_P3(200)) i_dut (.*);
  mcc_cpu_model i_cpu (.clock(clock), .go_halt(gh), .go_wake(gw), .go_mask(gm),
    .halt_req(halt_req), .halt_wake(halt_wake), .cpu_irq_masked(cpu_irq_masked));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, e);
    samples_checked++;
    if (a !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1; n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1 && n < 20);
    if (n >= 20) begin num_errors++; report_and_stop(); end
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  // Cycles up to the next overflow pulse
  task automatic wpulse(output int c);
    c = 0;
    do begin @(posedge clock); c++; end while (wake_from_wait !== 1 && c < 1000);
    if (c >= 1000) begin num_errors++; report_and_stop(); end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1;
    repeat (3) @(posedge clock);
    for (i = 0; i < 4; i++) begin apb(0, 12'(4 * i), 0); chk(rd, 0); end
    apb(0, 12'h010, 0); chk({rd[30:0], err}, 1);
    for (i = 0; i < 8; i++) begin
      csr = $random(seed) & 32'hFE;
      apb(1, 0, csr); apb(0, 0, 0); chk(rd & 32'hFE, csr);
    end
    $display("test registers done");
    for (i = 0; i < 5; i++) begin
      apb(1, 0, (i < 4) ? 32'h10 | (i << 5) : 0); k = 0;
      repeat (32) begin @(posedge clock); k += cpu_clk_en; end
      chk(k, (i < 4) ? 32 >> (i + 1) : 32);
    end
    $display("test prescaler done");
    for (i = 0; i < 4; i++) begin
      apb(1, 0, (i << 2) | 2); wpulse(k); wpulse(k); wpulse(k);
      chk(k, per[i]);
    end
    apb(0, 0, 0); chk(rd[0], 1); apb(0, 0, 0); chk(rd[0], 0);
    apb(1, 12'h00C, 1); wpulse(k); @(posedge clock);
    chk({irq, timebase_irq}, 3);
    apb(0, 12'h008, 0); chk(rd, 1); chk(irq, 0);
    gm <= 1; wpulse(k); repeat (2) @(posedge clock); chk(timebase_irq, 0);
    gm <= 0; repeat (3) @(posedge clock); chk(timebase_irq, 1);
    $display("test timer done");
    apb(1, 0, 32'h8E); gh <= 1; @(posedge clock); gh <= 0;
    repeat (3) @(posedge clock); chk(active_halt, 1);
    apb(1, 0, 0); wpulse(k); repeat (3) @(posedge clock); chk(active_halt, 0);
    apb(0, 0, 0); chk(rd & 32'hFE, 32'h8E);
    k = clk_out_pin; @(posedge clock); chk(clk_out_pin, !k);
    apb(1, 0, 0); gh <= 1; @(posedge clock); gh <= 0;
    repeat (3) @(posedge clock); chk(active_halt, 0);
    apb(1, 0, 32'h10); apb(0, 0, 0); chk(rd & 32'hFE, 0);
    gw <= 1; @(posedge clock); gw <= 0; repeat (3) @(posedge clock);
    apb(1, 0, 32'h10); apb(0, 0, 0); chk(rd & 32'hFE, 32'h10);
    for (i = 0; i < 4; i++) begin
      apb(1, 4, (i + 1) % 4); repeat (2) @(posedge clock);
      chk(tone_en, i < 3);
      if (i < 3) begin
        k = tone_out_pin; n = 0;
        do begin @(posedge clock); n++; end while (tone_out_pin === k && n < 1100);
        k = tone_out_pin; n = 0;
        do begin @(posedge clock); n++; end while (tone_out_pin === k && n < 1100);
        chk(n, 250 << i);
      end else chk(tone_out_pin, 0);
    end
    $display("test halt and beeper done");
    report_and_stop();
  end
endmodule
`default_nettype wire
